// File: logic/dio_defs.svh
// Constants for the 48-line open-drain digital I/O block with event sensing.
// Assumes a 25 MHz system clock and a 32-bit classic Wishbone register bus.
`ifndef DIO_DEFS_SVH
`define DIO_DEFS_SVH
// Register word indices; byte address is four times the index.
`define IDX_PORT6 4'h6
`define IDX_PORT7 4'h7
`define IDX_ICR 4'h8
`define IDX_VHR 4'h9
// Interrupt control register fields.
`define ICR_EN_BIT 0
`define ICR_SOFT_BIT 1
// Bank select field of the port 7 register.
`define BANK_MSB 7
`define BANK_LSB 6
// Unlock sequence written to port 7.
`define UNLOCK_B0 8'h07
`define UNLOCK_B1 8'h0d
`define UNLOCK_B2 8'h06
`define UNLOCK_B3 8'h12
// Debounce times in nanoseconds and the system clock period.
`define CLK_PERIOD_NS 40
`define DB_T0_NS 4000
`define DB_T1_NS 64000
`define DB_T2_NS 1000000
`define DB_T3_NS 8000000
`define NS_TO_CYC(t) (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Debounce counts in edges of the alternate clock on the top line.
`define DB_EXT0 18'h00020
`define DB_EXT1 18'h00200
`define DB_EXT2 18'h01f40
`define DB_EXT3 18'h0fa00
`endif

// File: logic/dio_pkg.sv
// Types shared by the digital I/O block and its debounce filter.
// Assumes dio_defs.svh is on the include path.
package dio_pkg;
  typedef enum logic [1:0] {
    BANK_IO = 2'h0,
    BANK_EVENT = 2'h1,
    BANK_DEBOUNCE = 2'h2
  } bank_t;
  // Gray codes along the unlock path.
  typedef enum logic [2:0] {
    UL_IDLE = 3'h0,
    UL_GOT1 = 3'h1,
    UL_GOT2 = 3'h3,
    UL_GOT3 = 3'h2,
    UL_DONE = 3'h6,
    UL_FAIL = 3'h7
  } unlock_t;
  typedef struct packed {
    logic ack;
    logic [7:0] vector;
  } intsel_ans_t;
endpackage

// File: logic/line_filter.sv
// Debounce filter for one byte-wide port of input lines.
// Assumes raw_i is already synchronised to clk_i and tick_i is a one-cycle count enable.
module line_filter
  import dio_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic enable_i,
  input wire logic tick_i,
  input wire logic [17:0] limit_i,
  // Data
  input wire logic [7:0] raw_i,
  output logic [7:0] clean_o
);
  logic [17:0] cnt [8];

  always_ff @(posedge clk_i) begin
    for (int i = 0; i < 8; i++) begin
      if (rst_i || !enable_i) begin
        cnt[i] <= 18'h0;
        clean_o[i] <= raw_i[i];
      end else if (raw_i[i] == clean_o[i]) begin
        cnt[i] <= 18'h0;
      end else if (tick_i) begin
        // A change is taken only after it held for the whole limit.
        if (cnt[i] + 18'h1 >= limit_i) begin
          cnt[i] <= 18'h0;
          clean_o[i] <= raw_i[i];
        end else begin
          cnt[i] <= cnt[i] + 18'h1;
        end
      end
    end
  end
endmodule

// File: logic/dio_event_core.sv
// Top of the 48-line open-drain digital I/O block: ports, unlock, banks, events, debounce.
// Assumes a classic Wishbone master, asynchronous field inputs and an external pull-up per line.
//
// Notes on behaviour
// - Reset releases all outputs and returns to standard mode.
// - Any reset clears every port write mask.
// - Reset clears, disables and sets negative polarity on all event channels.
// - Bus reset clears control and vector registers; soft reset keeps them.
// - Writing one to control bit 1 fires a soft reset of the core.
// - Ports 0 to 5 each map eight consecutive lines 0 to 47.
// - Port reads return the inverted pin level, reflecting own outputs.
// - A masked port ignores host writes to its output drivers.
// - Enhanced mode needs exactly 07,0D,06,12 to port 7 right after reset.
// - Enhanced mode offers I/O, event and debounce banks of eight registers.
// - Event polarity is selectable per nibble of four lines.
// - Event sensing works only in enhanced mode with per-channel enables.
// - A channel latches no event until enabled.
// - Enabled debounce requires stable input for the full time before acceptance.
// - Debounce timebase is the system clock or the top line alternate clock.
// - System clock timebase offers 4us, 64us, 1ms or 8ms.
// - Writing zero to an event bit clears its flag and disables it.
// - A channel is re-armed only by writing one after the clearing zero.
// - Control bit 0 gates latched events onto the request line.
// - An interrupt select cycle returns the vector with no wait state.
// - The request is released when flags clear or control bit 0 clears.
// - Enhanced port reads give levels in bank 0, event flags in bank 1.
// - Port 7 bits 7 and 6 select and report the bank; 11 is invalid.
// - Clock select bit 0 picks the top line at zero, system clock at one.
`include "dio_defs.svh"
module dio_event_core
  import dio_pkg::*;
#(
  parameter int DB_CYC_1MS = `NS_TO_CYC(`DB_T2_NS),
  parameter int DB_CYC_8MS = `NS_TO_CYC(`DB_T3_NS)
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [5:2] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Field lines, open drain
  input wire logic [47:0] line_i,
  output logic [47:0] line_o,
  output logic [47:0] line_oe_o,
  // Interrupt request and select cycle
  output logic intreq_n_o,
  input wire logic intsel_i,
  output intsel_ans_t intsel_o
);
  logic soft_rst;
  logic core_rst;
  logic [47:0] sync1;
  logic [47:0] sync2;
  logic alt_clk_prev;
  logic [47:0] level;
  logic [47:0] level_prev;
  logic [47:0] clean;
  logic [47:0] drive;
  logic [5:0] wmask;
  unlock_t unlock;
  logic enhanced;
  bank_t bank;
  logic [11:0] pol;
  logic [47:0] ev_en;
  logic [47:0] ev_flag;
  logic [5:0] db_en;
  logic [11:0] db_dur;
  logic db_sysclk;
  logic ier_en;
  logic [7:0] vhr;
  logic acc;
  logic wr;
  logic [7:0] wdat;
  logic [7:0] next_rdat;
  logic [47:0] edge_hit;
  logic [47:0] ev_set;

  function automatic logic [17:0] db_limit(input logic sysclk, input logic [1:0] code);
    logic [17:0] r;
    r = 18'h0;
    case (code)
      2'h0: r = sysclk ? 18'(`NS_TO_CYC(`DB_T0_NS)) : `DB_EXT0;
      2'h1: r = sysclk ? 18'(`NS_TO_CYC(`DB_T1_NS)) : `DB_EXT1;
      2'h2: r = sysclk ? 18'(DB_CYC_1MS) : `DB_EXT2;
      default: r = sysclk ? 18'(DB_CYC_8MS) : `DB_EXT3;
    endcase
    return r;
  endfunction

  assign core_rst = rst_i || soft_rst;
  assign acc = cyc_i && stb_i && ack_o;
  assign wr = acc && we_i && sel_i[0];
  assign wdat = dat_i[7:0];

  always_ff @(posedge clk_i) begin
    sync1 <= line_i;
    sync2 <= sync1;
    alt_clk_prev <= sync2[47];
  end

  // Only the system clock timebase has a fixed rate; the top line clock is free-running outside.
  for (genvar p = 0; p < 6; p++) begin : g_port
    line_filter u_filter (
      .clk_i(clk_i),
      .rst_i(core_rst),
      .enable_i(enhanced && db_en[p]),
      .tick_i(db_sysclk || (sync2[47] && !alt_clk_prev)),
      .limit_i(db_limit(db_sysclk, db_dur[2*p +: 2])),
      .raw_i(sync2[8*p +: 8]),
      .clean_o(clean[8*p +: 8])
    );
  end

  always_comb begin
    for (int p = 0; p < 6; p++) begin
      level[8*p +: 8] = (enhanced && db_en[p]) ? clean[8*p +: 8] : sync2[8*p +: 8];
    end
  end

  always_comb begin
    for (int i = 0; i < 48; i++) begin
      edge_hit[i] = pol[i/4] ? (level[i] && !level_prev[i]) : (!level[i] && level_prev[i]);
    end
  end
  assign ev_set = edge_hit & ev_en & {48{enhanced}};

  always_ff @(posedge clk_i) begin
    soft_rst <= wr && adr_i == `IDX_ICR && wdat[`ICR_SOFT_BIT];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ier_en <= 1'b0;
      vhr <= 8'h0;
    end else if (wr && adr_i == `IDX_ICR) begin
      ier_en <= wdat[`ICR_EN_BIT];
    end else if (wr && adr_i == `IDX_VHR) begin
      vhr <= wdat;
    end
  end

  always_ff @(posedge clk_i) begin
    if (core_rst) begin
      unlock <= UL_IDLE;
    end else if (acc && unlock != UL_DONE && unlock != UL_FAIL) begin
      // Any other access breaks the sequence until the next reset.
      unlock <= UL_FAIL;
      if (we_i && adr_i == `IDX_PORT7) begin
        case (unlock)
          UL_IDLE: if (wdat == `UNLOCK_B0) unlock <= UL_GOT1;
          UL_GOT1: if (wdat == `UNLOCK_B1) unlock <= UL_GOT2;
          UL_GOT2: if (wdat == `UNLOCK_B2) unlock <= UL_GOT3;
          UL_GOT3: if (wdat == `UNLOCK_B3) unlock <= UL_DONE;
          default: unlock <= UL_FAIL;
        endcase
      end
    end
  end
  assign enhanced = unlock == UL_DONE;

  always_ff @(posedge clk_i) begin
    if (core_rst) begin
      drive <= 48'h0;
    end else if (wr && adr_i < 4'h6 && !wmask[adr_i[4:2]] && (!enhanced || bank == BANK_IO)) begin
      drive[8*adr_i[4:2] +: 8] <= wdat;
    end
  end

  always_ff @(posedge clk_i) begin
    if (core_rst) begin
      wmask <= 6'h0;
      bank <= BANK_IO;
    end else if (wr && adr_i == `IDX_PORT7) begin
      if (!enhanced) begin
        // Writes that belong to the unlock attempt leave the mask alone.
        if (unlock == UL_FAIL || (unlock == UL_IDLE && wdat != `UNLOCK_B0)) begin
          wmask <= wdat[5:0];
        end
      end else begin
        if (wdat[`BANK_MSB:`BANK_LSB] != 2'h3) begin
          bank <= bank_t'(wdat[`BANK_MSB:`BANK_LSB]);
        end
        if (bank == BANK_IO) begin
          wmask <= wdat[5:0];
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (core_rst) begin
      pol <= 12'h0;
    end else if (wr && enhanced && bank == BANK_EVENT) begin
      if (adr_i == `IDX_PORT6) begin
        pol[7:0] <= wdat;
      end else if (adr_i == `IDX_PORT7) begin
        pol[11:8] <= wdat[3:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (core_rst) begin
      ev_en <= 48'h0;
      ev_flag <= 48'h0;
    end else begin
      if (wr && enhanced && bank == BANK_EVENT && adr_i < 4'h6) begin
        ev_en[8*adr_i[4:2] +: 8] <= wdat;
        // A new edge in the clearing cycle is kept.
        ev_flag <= (ev_flag & ~({40'h0, ~wdat} << (8*adr_i[4:2]))) | ev_set;
      end else begin
        ev_flag <= ev_flag | ev_set;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (core_rst) begin
      db_en <= 6'h0;
      db_dur <= 12'h0;
      db_sysclk <= 1'b0;
    end else if (wr && enhanced && bank == BANK_DEBOUNCE) begin
      case (adr_i)
        4'h0: db_en <= wdat[5:0];
        4'h1: db_dur[7:0] <= wdat;
        4'h2: db_dur[11:8] <= wdat[3:0];
        4'h3: db_sysclk <= wdat[0];
        default: ;
      endcase
    end
  end

  always_comb begin
    next_rdat = 8'h0;
    if (adr_i < 4'h6) begin
      if (enhanced && bank == BANK_EVENT) begin
        next_rdat = ev_flag[8*adr_i[4:2] +: 8];
      end else if (!enhanced || bank == BANK_IO) begin
        // Open drain: a line pulled low, by us or outside, reads as one.
        next_rdat = ~level[8*adr_i[4:2] +: 8];
      end else if (adr_i == 4'h0) begin
        next_rdat = {2'h0, db_en};
      end else if (adr_i == 4'h3) begin
        next_rdat = {7'h0, db_sysclk};
      end
    end else if (adr_i == `IDX_PORT7) begin
      next_rdat = enhanced ? {bank, (bank == BANK_IO) ? wmask : 6'h0} : {2'h0, wmask};
    end else if (adr_i == `IDX_ICR) begin
      next_rdat = {6'h3f, 1'b0, ier_en};
    end else if (adr_i == `IDX_VHR) begin
      next_rdat = vhr;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0;
    end else begin
      ack_o <= cyc_i && stb_i && !ack_o;
      dat_o <= {24'h0, next_rdat};
    end
  end

  always_ff @(posedge clk_i) begin
    if (core_rst) begin
      level_prev <= 48'hffffffffffff;
    end else begin
      level_prev <= level;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      intreq_n_o <= 1'b1;
      intsel_o <= '0;
    end else begin
      intreq_n_o <= !(ier_en && |ev_flag);
      intsel_o.ack <= intsel_i && !intsel_o.ack;
      intsel_o.vector <= vhr;
    end
  end

  always_ff @(posedge clk_i) begin
    line_oe_o <= drive;
    line_o <= 48'h0;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_rst_release;
    $past(core_rst) |-> drive == 48'h0 && !enhanced ##1 line_oe_o == 48'h0;
  endproperty
  a_rst_release: assert property (p_rst_release) else $error("outputs or mode not reset");
  property p_mask_clr;
    $past(core_rst) |-> wmask == 6'h0 && ev_en == 48'h0 && pol == 12'h0;
  endproperty
  a_mask_clr: assert property (p_mask_clr) else $error("mask or event state not cleared");
  property p_soft_keep;
    soft_rst |=> $stable(ier_en) && $stable(vhr);
  endproperty
  a_soft_keep: assert property (p_soft_keep) else $error("soft reset altered control");
  property p_soft_fire;
    wr && adr_i == `IDX_ICR && wdat[`ICR_SOFT_BIT] |=> soft_rst ##1 unlock == UL_IDLE;
  endproperty
  a_soft_fire: assert property (p_soft_fire) else $error("soft reset not fired");
  property p_unlock;
    $rose(enhanced) |-> $past(unlock) == UL_GOT3 && $past(wdat) == `UNLOCK_B3;
  endproperty
  a_unlock: assert property (p_unlock) else $error("enhanced entered without sequence");
  property p_no_ev_std;
    !enhanced |-> ev_flag == 48'h0;
  endproperty
  a_no_ev_std: assert property (p_no_ev_std) else $error("event outside enhanced mode");
  property p_need_en;
    ((ev_flag & ~$past(ev_flag) & ~$past(ev_en)) == 48'h0);
  endproperty
  a_need_en: assert property (p_need_en) else $error("event latched while disabled");
  property p_req_gate;
    !ier_en |=> intreq_n_o;
  endproperty
  a_req_gate: assert property (p_req_gate) else $error("request driven while disabled");
  property p_vec;
    intsel_i && !intsel_o.ack |=> intsel_o.ack && intsel_o.vector == $past(vhr);
  endproperty
  a_vec: assert property (p_vec) else $error("select cycle answer wrong");
  property p_bank;
    enhanced |-> bank != 2'h3;
  endproperty
  a_bank: assert property (p_bank) else $error("invalid bank selected");

  c_enter: cover property ($rose(enhanced));
  c_req: cover property ($fell(intreq_n_o));
  c_soft: cover property (soft_rst && ier_en);
  c_sel: cover property (intsel_o.ack && !intreq_n_o);
endmodule

// File: verif/intsel_host.sv
// Carrier-side model that runs interrupt select cycles against the digital I/O block.
// Assumes the block answers a held select request with a one-cycle registered acknowledge.
module intsel_host
  import dio_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control from the bench
  input wire logic go_i,
  output logic [7:0] vec_o,
  output logic done_o,
  // Block side
  input wire logic intreq_n_i,
  input wire intsel_ans_t ans_i,
  output logic intsel_o
);
  // The request is held until the acknowledge is sampled, so a slow answer is still caught.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      intsel_o <= 1'b0;
      done_o <= 1'b0;
      vec_o <= 8'h00;
    end else if (intsel_o && ans_i.ack) begin
      intsel_o <= 1'b0;
      vec_o <= ans_i.vector;
      done_o <= 1'b1;
    end else if (go_i && !intreq_n_i && !intsel_o && !done_o) begin
      intsel_o <= 1'b1;
    end else if (!go_i) begin
      done_o <= 1'b0;
    end
  end
endmodule

// File: verif/dio_event_core_test.sv
// Self-checking bench for the digital I/O block with event sensing and debounce.
// Assumes the block answers every Wishbone request and each line has a pull-up.
module dio_event_core_test;
  timeunit 1ns;
  timeprecision 1ps;
  import dio_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [3:0] sel = 4'h0;
  logic alt_clk = 1'b0;
  logic alt_run = 1'b0;
  logic [31:0] dat_o;
  logic ack_o;
  logic [47:0] ext_low = 48'h0;
  logic [47:0] line_i;
  logic [47:0] line_o;
  logic [47:0] line_oe;
  logic intreq_n;
  logic intsel;
  logic go = 1'b0;
  logic [7:0] hvec;
  logic hdone;
  logic [7:0] q;
  intsel_ans_t ans;
  int mismatches = 0;
  int compares = 0;

  always #20 clk_i = ~clk_i;
  // Open drain with pull-up: low when the block or the far side sinks the line.
  assign line_i = ~(line_oe | ext_low | {alt_clk, 47'h0});
  // The slow debounce clock on the top line runs only while a test asks for it.
  always @(posedge clk_i) alt_clk <= alt_run && !alt_clk;

  dio_event_core #(.DB_CYC_1MS(50), .DB_CYC_8MS(80)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o), .line_i(line_i),
    .line_o(line_o), .line_oe_o(line_oe), .intreq_n_o(intreq_n), .intsel_i(intsel), .intsel_o(ans)
  );
  intsel_host host (
    .clk_i(clk_i), .rst_i(rst_i), .go_i(go), .vec_o(hvec), .done_o(hdone),
    .intreq_n_i(intreq_n), .ans_i(ans), .intsel_o(intsel)
  );

  task automatic check(input string name, input logic [47:0] got, input logic [47:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic bus(input logic [3:0] a, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hf;
    adr <= a;
    wdat <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      mismatches++;
    end
    q = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    sel <= 4'h0;
  endtask

  task automatic rd(input string name, input logic [3:0] a, input logic [7:0] exp);
    bus(a, 1'b0, 8'h00);
    check(name, {40'h0, q}, {40'h0, exp});
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic bus_reset();
    @(posedge clk_i);
    rst_i <= 1'b1;
    wait_cyc(8);
    rst_i <= 1'b0;
  endtask

  initial begin
    #2000000;
    mismatches++;
    summarize();
  end

  initial begin
    bus_reset();
    wait_cyc(3);
    check("oe after reset", line_oe, 48'h0);
    check("intreq after reset", {47'h0, intreq_n}, 48'h1);
    check("line_o idle", line_o, 48'h0);
    rd("floating read", 4'h0, 8'h00);
    for (int p = 0; p < 6; p++) begin
      bus(p[3:0], 1'b1, 8'(p + 1));
      wait_cyc(2);
      check("port lines", line_oe, 48'(p + 1) << (8 * p));
      rd("port readback", p[3:0], 8'(p + 1));
      bus(p[3:0], 1'b1, 8'h00);
    end
    bus(4'h0, 1'b1, 8'h81);
    bus(4'h7, 1'b1, 8'h01);
    bus(4'h0, 1'b1, 8'hff);
    wait_cyc(2);
    check("masked port", line_oe, 48'h81);
    rd("unmapped", 4'hc, 8'h00);
    bus(4'h9, 1'b1, 8'h5a);
    bus(4'h8, 1'b1, 8'h01);
    bus(4'h8, 1'b1, 8'h03);
    wait_cyc(4);
    check("soft reset lines", line_oe, 48'h0);
    bus(4'h0, 1'b1, 8'hff);
    wait_cyc(2);
    check("mask cleared", line_oe, 48'hff);
    rd("icr kept", 4'h8, 8'hfd);
    rd("vector kept", 4'h9, 8'h5a);
    bus_reset();
    wait_cyc(3);
    check("bus reset lines", line_oe, 48'h0);
    rd("icr cleared", 4'h8, 8'hfc);
    rd("vector cleared", 4'h9, 8'h00);
    bus_reset();
    // The unlock writes must be the very first accesses after reset.
    bus(4'h7, 1'b1, 8'h07);
    bus(4'h7, 1'b1, 8'h0d);
    bus(4'h7, 1'b1, 8'h06);
    bus(4'h7, 1'b1, 8'h12);
    bus(4'h7, 1'b1, 8'h40);
    rd("bank status", 4'h7, 8'h40);
    bus(4'h6, 1'b1, 8'h01);
    bus(4'h0, 1'b1, 8'hff);
    ext_low <= 48'h111;
    wait_cyc(10);
    ext_low <= 48'h110;
    wait_cyc(10);
    rd("flags by polarity", 4'h0, 8'h11);
    rd("disabled channel", 4'h1, 8'h00);
    bus(4'h9, 1'b1, 8'h3c);
    bus(4'h8, 1'b1, 8'h01);
    wait_cyc(3);
    check("request low", {47'h0, intreq_n}, 48'h0);
    go <= 1'b1;
    for (int n = 0; n < 20 && hdone !== 1'b1; n++) @(posedge clk_i);
    check("select vector", {40'h0, hvec}, 48'h3c);
    go <= 1'b0;
    ext_low <= 48'h0;
    bus(4'h0, 1'b1, 8'h00);
    wait_cyc(3);
    check("request released", {47'h0, intreq_n}, 48'h1);
    rd("flags cleared", 4'h0, 8'h00);
    ext_low <= 48'h1;
    wait_cyc(10);
    ext_low <= 48'h0;
    wait_cyc(10);
    rd("not rearmed", 4'h0, 8'h00);
    bus(4'h0, 1'b1, 8'hff);
    ext_low <= 48'h1;
    wait_cyc(10);
    ext_low <= 48'h0;
    wait_cyc(10);
    rd("rearmed", 4'h0, 8'h01);
    bus(4'h8, 1'b1, 8'h00);
    wait_cyc(3);
    check("enable cleared", {47'h0, intreq_n}, 48'h1);
    bus(4'h7, 1'b1, 8'h80);
    bus(4'h3, 1'b1, 8'h01);
    bus(4'h1, 1'b1, 8'h00);
    bus(4'h0, 1'b1, 8'h01);
    rd("debounce enable", 4'h0, 8'h01);
    rd("clock select sys", 4'h3, 8'h01);
    bus(4'h7, 1'b1, 8'h00);
    // The filter takes the present level when enabled, so reads hold at once; this wait only spaces the steps.
    wait_cyc(120);
    ext_low <= 48'h2;
    wait_cyc(40);
    rd("glitch filtered", 4'h0, 8'h00);
    ext_low <= 48'h0;
    wait_cyc(20);
    ext_low <= 48'h202;
    wait_cyc(150);
    rd("stable accepted", 4'h0, 8'h02);
    rd("bank0 level", 4'h1, 8'h02);
    ext_low <= 48'h0;
    bus(4'h7, 1'b1, 8'h80);
    bus(4'h3, 1'b1, 8'h00);
    rd("clock select alt", 4'h3, 8'h00);
    bus(4'h7, 1'b1, 8'h00);
    alt_run <= 1'b1;
    // Shortest code on the top line clock is 32 of its rising edges, one every two cycles here.
    wait_cyc(200);
    ext_low <= 48'h2;
    wait_cyc(40);
    rd("slow glitch filtered", 4'h0, 8'h00);
    ext_low <= 48'h0;
    wait_cyc(20);
    ext_low <= 48'h2;
    wait_cyc(100);
    rd("slow stable accepted", 4'h0, 8'h02);
    ext_low <= 48'h0;
    alt_run <= 1'b0;
    summarize();
  end
endmodule
